// ==== iex_core.v ====
// iex_core.v: executes a subset of 14-bit instructions issued over AHB-Lite
// assumes a single AHB-Lite master and one slave; hreadyout is bus hready
//
// Overview of operation
// (RULE1) literal OR into accumulator, one cycle
// (RULE2) OR sets zero flag only on zero
// (RULE3) return pops stack into PC, two cycles
// (RULE4) rotate right through carry, carry only
// (RULE5) rotate left through carry, carry only
// (RULE6) destination bit picks accumulator or file
// (RULE7) sleep clears power-down, sets time-out flag
// (RULE8) sleep clears watchdog, prescaler, stops oscillator
`include "iex_map.vh"
`default_nettype none

module iex_core #(
    parameter STACK_DEPTH_LOG2 = `IEX_SP_W
) (
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    // core state
    output wire        osc_run,
    output wire [7:0]  accumulator
);
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_EXEC = 4'h2;
    localparam [3:0] S_SEC  = 4'h4;
    localparam [3:0] S_FIN  = 4'h8;
    localparam SD = 1 << STACK_DEPTH_LOG2;

    reg  [3:0]               state_r;
    reg  [3:0]               state_nxt;
    reg  [13:0]              ir_r;
    reg  [7:0]               acc_r;
    reg  [7:0]               status_r;
    reg  [`IEX_PC_W-1:0]     pc_r;
    reg  [STACK_DEPTH_LOG2-1:0] sp_r;
    reg  [`IEX_PC_W-1:0]     stack_r [0:SD-1];
    reg  [`IEX_FA_W-1:0]     faddr_r;
    reg  [7:0]               wdt_r;
    reg  [7:0]               pre_r;
    reg                      sleep_r;
    reg                      dp_valid_r;
    reg                      dp_write_r;
    reg  [7:0]               dp_ofs_r;
    reg  [31:0]              rd_r;
    reg                      rd_ram_r;

    wire        ap_take = hsel & hready & htrans[1];
    wire        dp_wr   = dp_valid_r & dp_write_r;
    wire        instr_dp = dp_wr & (dp_ofs_r == `IEX_OFS_INSTR);
    wire        op_ior  = (ir_r[13:8] == `IEX_OP_IOR_HI);
    wire        op_ret  = (ir_r == `IEX_OP_RETURN);
    wire        op_slp  = (ir_r == `IEX_OP_SLEEP);
    wire        op_rrf  = (ir_r[13:8] == `IEX_OP_RRF_HI);
    wire        op_rlf  = (ir_r[13:8] == `IEX_OP_RLF_HI);
    wire        op_rot  = op_rrf | op_rlf;
    wire        to_file = ir_r[`IEX_IR_D];
    wire [7:0]  ram_q;
    wire [7:0]  ior_res = acc_r | ir_r[7:0];                     // RULE1
    wire        old_c   = status_r[`IEX_ST_C];
    wire [7:0]  rot_res = op_rrf ? {old_c, ram_q[7:1]}           // RULE4
                                 : {ram_q[6:0], old_c};          // RULE5
    wire        rot_c   = op_rrf ? ram_q[0] : ram_q[7];
    wire        in_sec  = (state_r == S_SEC);
    wire        in_exec = (state_r == S_EXEC);
    wire        rot_wr  = in_sec & op_rot & to_file;             // RULE6
    wire        bus_fwr = dp_wr & (dp_ofs_r == `IEX_OFS_FDATA);
    wire        faddr_wr = dp_wr & (dp_ofs_r == `IEX_OFS_FADDR);

    // an instruction write holds the data phase until execution ends
    assign hreadyout   = ~instr_dp | (state_r == S_FIN);
    assign hresp       = 1'b0;
    assign hrdata      = rd_ram_r ? {24'h000000, ram_q} : rd_r;
    assign osc_run     = ~sleep_r;
    assign accumulator = acc_r;

    // bus address wins only when no instruction is in S_EXEC or S_SEC
    reg                  ram_we;
    reg [`IEX_FA_W-1:0]  ram_addr;
    reg [7:0]            ram_wd;
    always @* begin
        ram_we   = 1'b0;
        ram_addr = faddr_wr ? hwdata[`IEX_FA_W-1:0] : faddr_r;
        ram_wd   = hwdata[7:0];
        if (in_exec || in_sec) begin
            ram_addr = ir_r[`IEX_FA_W-1:0];
            ram_we   = rot_wr;
            ram_wd   = rot_res;
        end else if (bus_fwr) begin
            ram_we   = 1'b1;
        end
    end

    iex_ram #(
        .AW (`IEX_FA_W),
        .DW (8)
    ) u_ram (
        .clk   (hclk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wd),
        .rdata (ram_q)
    );

    always @* begin
        case (state_r)
            S_IDLE:  state_nxt = instr_dp ? S_EXEC : S_IDLE;
            S_EXEC:  state_nxt = ((op_ret | op_rot) & ~sleep_r) ? S_SEC
                                                                 : S_FIN;
            S_SEC:   state_nxt = S_FIN;
            S_FIN:   state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // read mux, sampled in the address phase
    reg [31:0] rd_nxt;
    always @* begin
        case (haddr[7:0])
            `IEX_OFS_ACC:    rd_nxt = {24'h000000, acc_r};
            `IEX_OFS_STATUS: rd_nxt = {24'h000000, status_r};
            `IEX_OFS_PC:     rd_nxt = {19'h00000, pc_r};
            `IEX_OFS_STACK:  rd_nxt = {{(32-STACK_DEPTH_LOG2){1'b0}}, sp_r};
            `IEX_OFS_FADDR:  rd_nxt = {25'h0000000, faddr_r};
            `IEX_OFS_WDT:    rd_nxt = {16'h0000, pre_r, wdt_r};
            `IEX_OFS_CTRL:   rd_nxt = {31'h00000000, sleep_r};
            default:         rd_nxt = 32'h00000000;
        endcase
    end

    integer i;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r    <= S_IDLE;
            ir_r       <= 14'h0000;
            acc_r      <= 8'h00;
            status_r   <= `IEX_ST_RESET;
            pc_r       <= 13'h0000;
            sp_r       <= {STACK_DEPTH_LOG2{1'b0}};
            for (i = 0; i < SD; i = i + 1) begin
                stack_r[i] <= 13'h0000;
            end
            faddr_r    <= 7'h00;
            wdt_r      <= `IEX_WDT_CLR;
            pre_r      <= `IEX_PRE_CLR;
            sleep_r    <= 1'b0;
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_ofs_r   <= 8'h00;
            rd_r       <= 32'h00000000;
            rd_ram_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (hready) begin
                dp_valid_r <= ap_take;
                dp_write_r <= hwrite;
                dp_ofs_r   <= haddr[7:0];
                rd_r       <= rd_nxt;
                rd_ram_r   <= ap_take & ~hwrite
                              & (haddr[7:0] == `IEX_OFS_FDATA);
            end
            // watchdog runs while the oscillator runs
            if (!sleep_r) begin
                pre_r <= pre_r + 8'h01;
                if (pre_r == `IEX_PRE_TOP) begin
                    wdt_r <= wdt_r + 8'h01;
                end
            end
            // software register writes
            if (dp_wr && state_r == S_IDLE) begin
                case (dp_ofs_r)
                    `IEX_OFS_INSTR:  ir_r     <= hwdata[13:0];
                    `IEX_OFS_ACC:    acc_r    <= hwdata[7:0];
                    `IEX_OFS_STATUS: status_r <= hwdata[7:0];
                    `IEX_OFS_PC:     pc_r     <= hwdata[12:0];
                    `IEX_OFS_FADDR:  faddr_r  <= hwdata[6:0];
                    `IEX_OFS_CTRL:   sleep_r  <= sleep_r & hwdata[0];
                    `IEX_OFS_STACK: begin
                        stack_r[sp_r] <= hwdata[12:0];
                        sp_r          <= sp_r + 1'b1;
                    end
                    default: ;
                endcase
            end
            // instructions are ignored while the core sleeps
            if (in_exec && !sleep_r) begin
                if (op_ior) begin
                    acc_r <= ior_res;                            // RULE1
                    status_r[`IEX_ST_Z] <= (ior_res == 8'h00);   // RULE2
                end
                if (op_ret) begin
                    sp_r <= sp_r - 1'b1;                         // RULE3
                end
                if (op_slp) begin
                    status_r[`IEX_ST_PD] <= 1'b0;                // RULE7
                    status_r[`IEX_ST_TO] <= 1'b1;                // RULE7
                    wdt_r   <= `IEX_WDT_CLR;                     // RULE8
                    pre_r   <= `IEX_PRE_CLR;                     // RULE8
                    sleep_r <= 1'b1;                             // RULE8
                end
            end
            if (in_sec && op_ret) begin
                pc_r <= stack_r[sp_r];                           // RULE3
            end
            if (in_sec && op_rot) begin
                status_r[`IEX_ST_C] <= rot_c;                    // RULE4
                if (!to_file) begin
                    acc_r <= rot_res;                            // RULE6
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== iex_map.vh ====
// iex_map.vh: constants of the instruction execution subset block
// assumes inclusion by iex_core.v and by the verification files
`ifndef IEX_MAP_VH
`define IEX_MAP_VH

// register byte offsets on the AHB-Lite slave
`define IEX_OFS_INSTR     8'h00
`define IEX_OFS_ACC       8'h04
`define IEX_OFS_STATUS    8'h08
`define IEX_OFS_PC        8'h0C
`define IEX_OFS_STACK     8'h10
`define IEX_OFS_FADDR     8'h14
`define IEX_OFS_FDATA     8'h18
`define IEX_OFS_WDT       8'h1C
`define IEX_OFS_CTRL      8'h20

// status field positions and reset value
`define IEX_ST_C          0
`define IEX_ST_Z          2
`define IEX_ST_PD         3
`define IEX_ST_TO         4
`define IEX_ST_RESET      8'h18

// opcode patterns
`define IEX_OP_IOR_HI     6'h38
`define IEX_OP_RETURN     14'h0008
`define IEX_OP_SLEEP      14'h0063
`define IEX_OP_RRF_HI     6'h0C
`define IEX_OP_RLF_HI     6'h0D
`define IEX_IR_D          7

// widths and clear values
`define IEX_PC_W          13
`define IEX_SP_W          3
`define IEX_FA_W          7
`define IEX_WDT_CLR       8'h00
`define IEX_PRE_CLR       8'h00
`define IEX_PRE_TOP       8'hFF

`endif

// ==== iex_ram.v ====
// iex_ram.v: single port file register memory with registered read data
// assumes one clock; read data appear on the edge after the address
`default_nettype none

module iex_ram #(
    parameter AW = 7,
    parameter DW = 8
) (
    // clock
    input  wire          clk,
    // port
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // no reset: contents are undefined until software writes them
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

`default_nettype wire

// ==== iex_core_asserts.sv ====
// iex_core_asserts.sv: port level checks of iex_core
// assumes hready is tied to hreadyout and one master drives the bus
`include "iex_map.vh"
`default_nettype none
module iex_chk (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // AHB-Lite slave side
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // core state
    input wire logic        osc_run,
    input wire logic [7:0]  accumulator
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       dp_r, osc_s;
    logic [7:0] acc_s;
    logic [2:0] wcnt;
    wire        fin = dp_r && hready && osc_s;
    wire [13:0] op  = hwdata[13:0];
    wire        ior = op[13:8] == `IEX_OP_IOR_HI;
    wire        slp = op == `IEX_OP_SLEEP;
    wire        ret = op == `IEX_OP_RETURN;
    wire        rot = op[13:8] == `IEX_OP_RRF_HI ||
                      op[13:8] == `IEX_OP_RLF_HI;
    // state is captured at the address phase so the data phase end can
    // be judged against it; wcnt counts the wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_r  <= 1'b0;
            osc_s <= 1'b1;
            acc_s <= 8'h00;
            wcnt  <= 3'h0;
        end else if (hready) begin
            dp_r  <= hsel && htrans[1] && hwrite &&
                     haddr[7:0] == `IEX_OFS_INSTR;
            osc_s <= osc_run;
            acc_s <= accumulator;
            wcnt  <= 3'h0;
        end else begin
            wcnt  <= wcnt + 3'h1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    or_wait_a: assert property (fin && ior |-> wcnt == 3'h2)
        else $error("or literal wait count wrong");
    or_acc_a: assert property (fin && ior |->
        accumulator == (acc_s | op[7:0])) else $error("or result wrong");
    ret_wait_a: assert property (fin && ret |-> wcnt == 3'h3)
        else $error("return wait count wrong");
    ret_acc_a: assert property (fin && ret |-> accumulator == acc_s)
        else $error("return changed accumulator");
    rot_wait_a: assert property (fin && rot |-> wcnt == 3'h3)
        else $error("rotate wait count wrong");
    rot_keep_a: assert property (fin && rot && op[7] |->
        accumulator == acc_s) else $error("rotate to file hit accumulator");
    sleep_wait_a: assert property (fin && slp |-> wcnt == 3'h2)
        else $error("sleep wait count wrong");
    sleep_osc_a: assert property (fin && slp |-> ##[0:1] !osc_run)
        else $error("oscillator still running after sleep");
    cover property (fin && ior);
    cover property (fin && rot && !op[7]);
    cover property (fin && slp);
endmodule
bind iex_core iex_chk chk_u (.*);
`default_nettype wire

// ==== iex_core_bench.sv ====
// iex_core_bench.sv: random and corner tests of iex_core over AHB-Lite
// assumes iex_core.v and iex_core_asserts.sv are compiled first
`include "iex_map.vh"
`default_nettype none
module iex_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, osc_run;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q, t, seed;
    logic [7:0]  accumulator, a, v, st;
    logic [8:0]  r;
    int          error_cnt, checks, i;
    iex_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .osc_run(osc_run),
        .accumulator(accumulator));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // rotate through carry, giving {new carry, result}
    function automatic logic [8:0] rot(logic [7:0] x, logic c, logic lf);
        return lf ? {x[7], x[6:0], c} : {x[0], c, x[7:1]};
    endfunction
    task automatic chk(logic [31:0] g, logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask
    // one single transfer, entered just after a rising edge; hready is
    // sampled at rising edges, only the watchdog ends a hung wait
    task automatic bus(logic w, logic [7:0] ad, logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, ad};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rc(logic [7:0] ad, logic [31:0] e, logic [31:0] m);
        bus(1'b0, ad, 32'h0);
        chk(q & m, e);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic conclude();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #50000;
        error_cnt++;
        conclude();
    end
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata} = '0;
        seed = 32'h00012AB2;
        error_cnt = 0;
        checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rc(`IEX_OFS_STATUS, 32'h18, 32'hFF);
        rc(`IEX_OFS_ACC, 32'h0, 32'hFF);
        rc(8'h40, 32'h0, 32'hFFFFFFFF);
        $display("test reset done");
        for (i = 0; i < 12; i++) begin
            t = rnd();
            a = (i == 0) ? 8'h00 : t[7:0];
            v = (i < 2) ? 8'h00 : t[15:8];
            st = t[23:16] & 8'h1D;
            bus(1'b1, `IEX_OFS_ACC, {24'h0, a});
            bus(1'b1, `IEX_OFS_STATUS, {24'h0, st});
            bus(1'b1, `IEX_OFS_INSTR, {18'h0, `IEX_OP_IOR_HI, v});
            st[`IEX_ST_Z] = (a | v) == 8'h00;
            rc(`IEX_OFS_ACC, {24'h0, a | v}, 32'hFF);
            rc(`IEX_OFS_STATUS, {24'h0, st}, 32'h1D);
        end
        $display("test or literal done");
        for (i = 0; i < 16; i++) begin
            t = rnd();
            a = t[7:0];
            v = t[15:8];
            st = t[23:16] & 8'h1D;
            bus(1'b1, `IEX_OFS_FADDR, {25'h0, t[30:24]});
            bus(1'b1, `IEX_OFS_FDATA, {24'h0, v});
            bus(1'b1, `IEX_OFS_ACC, {24'h0, a});
            bus(1'b1, `IEX_OFS_STATUS, {24'h0, st});
            bus(1'b1, `IEX_OFS_INSTR, {18'h0, i[0] ? `IEX_OP_RLF_HI :
                `IEX_OP_RRF_HI, i[1], t[30:24]});
            r = rot(v, st[`IEX_ST_C], i[0]);
            st[`IEX_ST_C] = r[8];
            rc(`IEX_OFS_ACC, {24'h0, i[1] ? a : r[7:0]}, 32'hFF);
            rc(`IEX_OFS_FDATA, {24'h0, i[1] ? r[7:0] : v}, 32'hFF);
            rc(`IEX_OFS_STATUS, {24'h0, st}, 32'h1D);
        end
        $display("test rotate done");
        t = rnd();
        bus(1'b1, `IEX_OFS_STACK, {19'h0, t[12:0]});
        bus(1'b1, `IEX_OFS_STACK, {19'h0, t[28:16]});
        bus(1'b1, `IEX_OFS_INSTR, {18'h0, `IEX_OP_RETURN});
        rc(`IEX_OFS_PC, {19'h0, t[28:16]}, 32'h1FFF);
        bus(1'b1, `IEX_OFS_INSTR, {18'h0, `IEX_OP_RETURN});
        rc(`IEX_OFS_PC, {19'h0, t[12:0]}, 32'h1FFF);
        rc(`IEX_OFS_STACK, 32'h0, 32'h7);
        rc(`IEX_OFS_STATUS, {24'h0, st}, 32'h1D);
        $display("test return done");
        bus(1'b1, `IEX_OFS_STATUS, 32'h0D);
        bus(1'b1, `IEX_OFS_INSTR, {18'h0, `IEX_OP_SLEEP});
        rc(`IEX_OFS_STATUS, 32'h15, 32'h1D);
        rc(`IEX_OFS_WDT, 32'h0, 32'hFFFF);
        chk({31'h0, osc_run}, 32'h0);
        bus(1'b1, `IEX_OFS_INSTR, {18'h0, `IEX_OP_IOR_HI, 8'hFF});
        rc(`IEX_OFS_ACC, {24'h0, a}, 32'hFF);
        bus(1'b1, `IEX_OFS_CTRL, 32'h0);
        @(negedge hclk);
        chk({31'h0, osc_run}, 32'h1);
        $display("test sleep done");
        conclude();
    end
endmodule
`default_nettype wire
